// ---- hdl/adc_conversion_sequencer.v ----
// What this block does
// - one conversion takes 9.5 bit conversion periods from start to result
// - bit period selectable: 2, 8, 32 oscillator periods or internal RC clock
// - clock select codes: 00 div2, 01 div8, 10 div32, 11 RC
// - port data reads return zero on every analog-configured pin
// - selected channel is converted even when configured digital
// - writing go while on starts conversion; go reads one while busy
// - clearing go during a conversion aborts it immediately
// - aborted conversion leaves result register unchanged
// - after abort wait two bit periods, then acquire selected channel
// - mid-conversion clock change only among oscillator settings, never RC
// - reduced resolution: later bits clocked at new, possibly too short period
// - with RC clock, wait one instruction cycle before converting
// - on completion clear go and load the 8-bit result
// - on completion set interrupt flag; stays until software clears
// - completion during sleep with interrupt enabled wakes the device
// - completion during sleep, interrupt disabled, powers module down; on bit stays
// - sleep with oscillator clock aborts and powers down; on bit stays
//
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`include "adc_regs.vh"
module adc_conversion_sequencer
(
  // clock and reset
  input wire clk_sys_in,
  input wire rst_in,
  // ahb-lite slave
  input wire hsel_in,
  input wire [7:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output wire hreadyout_out,
  output wire hresp_out,
  output reg [31:0] hrdata_out,
  // internal rc oscillator, one pulse per half bit period
  input wire rc_half_tick_in,
  // processor sleep state
  input wire sleep_in,
  output wire wake_out,
  // analog front end
  input wire comparator_in,
  output reg [7:0] trial_code_out,
  output reg [2:0] channel_out,
  output reg acquire_out,
  output reg module_powered_out,
  // port pins
  input wire [5:0] port_pins_in,
  output reg [5:0] port_direction_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DELAY = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [1:0] state_q, state_d;
  reg [1:0] sel_q;
  reg [2:0] chan_q;
  reg rsvd_q;
  reg on_q;
  reg [7:0] result_q;
  reg [2:0] pin_cfg_q;
  reg [5:0] dir_q;
  reg flag_q;
  reg irq_en_q;
  reg power_down_q;
  reg rc_mode_q;
  reg [1:0] osc_sel_q;
  reg [4:0] div_q;
  reg [4:0] half_cnt_q;
  reg [2:0] delay_q;
  reg [7:0] trial_q;
  reg [7:0] mask_q;
  // latched ahb address phase
  reg wr_pend_q;
  reg [7:0] wr_addr_q;

  wire [7:0] rst_ctl = `RST_CONTROL;
  wire addr_ok = hsel_in && hready_in && htrans_in[1];
  wire powered = on_q && !power_down_q;
  wire busy = (state_q == ST_DELAY) || (state_q == ST_CONV);
  wire wr_ctl = wr_pend_q && (wr_addr_q == `OFS_CONV_CONTROL);
  wire go_set = wr_ctl && hwdata_in[`CTL_GO];
  wire go_clr = wr_ctl && !hwdata_in[`CTL_GO];
  wire wr_res = wr_pend_q && (wr_addr_q == `OFS_CONV_RESULT);
  wire wr_irq = wr_pend_q && (wr_addr_q == `OFS_IRQ);
  wire [1:0] sel_now = wr_ctl ? hwdata_in[`CTL_SEL_HI:`CTL_SEL_LO] : sel_q;

  // analog pins per port configuration; bit 4 is never analog
  function [5:0] analog_mask;
    input [2:0] cfg;
    begin
      case (cfg)
        3'h0, 3'h2: analog_mask = 6'h2F;
        3'h1, 3'h3: analog_mask = 6'h27;
        3'h4: analog_mask = 6'h0B;
        default: analog_mask = 6'h00;
      endcase
    end
  endfunction

  // half bit period tick: rc ticks in rc mode, oscillator divider otherwise
  wire [4:0] half_len = (osc_sel_q == `SEL_DIV2) ? `HALF_DIV2 :
                        (osc_sel_q == `SEL_DIV8) ? `HALF_DIV8 : `HALF_DIV32;
  wire osc_tick = (div_q + 5'h01 >= half_len);
  wire half_tick = rc_mode_q ? rc_half_tick_in : osc_tick;
  wire conv_done = (state_q == ST_CONV) && half_tick && (half_cnt_q == `CONV_HALVES - 5'h01);
  wire sleep_abort = sleep_in && busy && !rc_mode_q;
  wire sw_abort = go_clr && busy;
  wire start_ok = go_set && powered && !busy && !sleep_in;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_ok)
          state_d = (sel_now == `SEL_RC) ? ST_DELAY : ST_CONV;
      end
      ST_DELAY:
      begin
        if (sw_abort)
          state_d = ST_WAIT;
        else if (delay_q == `INSTR_CYCLES - 3'h1)
          state_d = ST_CONV;
      end
      ST_CONV:
      begin
        if (sw_abort || conv_done)
          state_d = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (start_ok)
          state_d = (sel_now == `SEL_RC) ? ST_DELAY : ST_CONV;
        else if (half_tick && (half_cnt_q == `WAIT_HALVES - 5'h01))
          state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (sleep_abort || !powered)
      state_d = ST_IDLE;
  end

  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_IDLE;
      sel_q <= rst_ctl[`CTL_SEL_HI:`CTL_SEL_LO];
      chan_q <= 3'h0;
      rsvd_q <= 1'b0;
      on_q <= 1'b0;
      result_q <= `RST_RESULT;
      pin_cfg_q <= `RST_PIN_CONFIG;
      dir_q <= `RST_PORT_DIRECTION;
      flag_q <= 1'b0;
      irq_en_q <= 1'b0;
      power_down_q <= 1'b0;
      rc_mode_q <= 1'b0;
      osc_sel_q <= `SEL_DIV2;
      div_q <= 5'h00;
      half_cnt_q <= 5'h00;
      delay_q <= 3'h0;
      trial_q <= 8'h80;
      mask_q <= 8'h80;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      wr_pend_q <= addr_ok && hwrite_in;
      wr_addr_q <= haddr_in;
      if (wr_ctl)
      begin
        sel_q <= hwdata_in[`CTL_SEL_HI:`CTL_SEL_LO];
        chan_q <= hwdata_in[`CTL_CHAN_HI:`CTL_CHAN_LO];
        rsvd_q <= hwdata_in[`CTL_RSVD];
        on_q <= hwdata_in[`CTL_ON];
      end
      if (wr_pend_q && (wr_addr_q == `OFS_PIN_CONFIG))
        pin_cfg_q <= hwdata_in[2:0];
      if (wr_pend_q && (wr_addr_q == `OFS_PORT_DIRECTION))
        dir_q <= hwdata_in[5:0];
      if (wr_irq)
        irq_en_q <= hwdata_in[`IRQ_ENABLE];
      // completion beats a simultaneous software clear of the flag
      if (conv_done)
        flag_q <= 1'b1;
      else if (wr_irq && hwdata_in[`IRQ_FLAG])
        flag_q <= 1'b0;
      // result only moves on a finished conversion or a software write
      if (conv_done)
        result_q <= (trial_q & ~(comparator_in ? 8'h00 : mask_q));
      else if (wr_res)
        result_q <= hwdata_in[7:0];
      // power down leaves the on bit set; cleared by waking or by writing the on bit to zero
      if (sleep_abort)
        power_down_q <= 1'b1;
      else if (conv_done && sleep_in && !irq_en_q)
        power_down_q <= 1'b1;
      else if (!sleep_in || (wr_ctl && !hwdata_in[`CTL_ON]))
        power_down_q <= 1'b0;
      // rc vs oscillator source is fixed for the whole conversion
      if (state_q == ST_IDLE || state_q == ST_WAIT)
        rc_mode_q <= (sel_now == `SEL_RC);
      if (sel_now != `SEL_RC)
        osc_sel_q <= sel_now;
      if (state_d != state_q || osc_tick)
        div_q <= 5'h00;
      else
        div_q <= div_q + 5'h01;
      if (state_d != state_q)
        half_cnt_q <= 5'h00;
      else if (half_tick)
        half_cnt_q <= half_cnt_q + 5'h01;
      if (state_q == ST_DELAY)
        delay_q <= delay_q + 3'h1;
      else
        delay_q <= 3'h0;
      // successive approximation, one decision per bit period after lead-in
      if (state_q != ST_CONV)
      begin
        trial_q <= 8'h80;
        mask_q <= 8'h80;
      end
      else if (half_tick && !half_cnt_q[0] && half_cnt_q >= `FIRST_DECISION)
      begin
        trial_q <= (trial_q & ~(comparator_in ? 8'h00 : mask_q)) | (mask_q >> 1);
        mask_q <= mask_q >> 1;
      end
    end
  end

  // analog side outputs, registered
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      trial_code_out <= 8'h80;
      channel_out <= 3'h0;
      acquire_out <= 1'b0;
      module_powered_out <= 1'b0;
      port_direction_out <= `RST_PORT_DIRECTION;
    end
    else
    begin
      trial_code_out <= trial_q;
      channel_out <= chan_q;
      acquire_out <= powered && (state_d == ST_IDLE) && !sleep_abort;
      module_powered_out <= powered;
      port_direction_out <= dir_q;
    end
  end

  assign wake_out = sleep_in && flag_q && irq_en_q;
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;

  // read data captured in the address phase, shown in the data phase
  always @(posedge clk_sys_in)
  begin
    if (rst_in)
      hrdata_out <= 32'h0000_0000;
    else if (addr_ok && !hwrite_in)
    begin
      case (haddr_in)
        `OFS_CONV_CONTROL:
          hrdata_out <= {24'h000000, sel_q, chan_q, busy, rsvd_q, on_q};
        `OFS_CONV_RESULT: hrdata_out <= {24'h000000, result_q};
        `OFS_PIN_CONFIG: hrdata_out <= {29'h00000000, pin_cfg_q};
        `OFS_PORT_DIRECTION: hrdata_out <= {26'h0000000, dir_q};
        `OFS_PORT_DATA:
          hrdata_out <= {26'h0000000, port_pins_in & ~analog_mask(pin_cfg_q)};
        `OFS_IRQ: hrdata_out <= {30'h00000000, irq_en_q, flag_q};
        default: hrdata_out <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ---- hdl/adc_regs.vh ----
`ifndef ADC_REGS_VH
`define ADC_REGS_VH
// register byte offsets
`define OFS_CONV_CONTROL 8'h00
`define OFS_CONV_RESULT 8'h04
`define OFS_PIN_CONFIG 8'h08
`define OFS_PORT_DIRECTION 8'h0C
`define OFS_PORT_DATA 8'h10
`define OFS_IRQ 8'h14
// conv_control_reg fields
`define CTL_SEL_HI 7
`define CTL_SEL_LO 6
`define CTL_CHAN_HI 5
`define CTL_CHAN_LO 3
`define CTL_GO 2
`define CTL_RSVD 1
`define CTL_ON 0
// irq register fields
`define IRQ_FLAG 0
`define IRQ_ENABLE 1
// clock select codes
`define SEL_DIV2 2'h0
`define SEL_DIV8 2'h1
`define SEL_DIV32 2'h2
`define SEL_RC 2'h3
// reset values
`define RST_CONTROL 8'h00
`define RST_RESULT 8'h00
`define RST_PIN_CONFIG 3'h0
`define RST_PORT_DIRECTION 6'h3F
// timing: half bit periods, in oscillator cycles
`define HALF_DIV2 5'h01
`define HALF_DIV8 5'h04
`define HALF_DIV32 5'h10
// one conversion is 19 half bit periods (9.5 bit periods)
`define CONV_HALVES 5'h13
// first bit decision after the 2 bit-period lead-in
`define FIRST_DECISION 5'h04
// wait of 2 bit periods after completion or abort, in halves
`define WAIT_HALVES 5'h04
// one instruction cycle is 4 oscillator cycles
`define INSTR_CYCLES 3'h4
`endif

// ---- verif/adc_seq_props.sv ----
`timescale 1ns/1ns
module adc_seq_props
(
  // clock, reset and bus
  input logic clk_sys_in,
  input logic rst_in,
  input logic hsel_in,
  input logic [7:0] haddr_in,
  input logic [1:0] htrans_in,
  input logic hwrite_in,
  input logic [31:0] hwdata_in,
  input logic hready_in,
  input logic hreadyout_out,
  input logic hresp_out,
  input logic [31:0] hrdata_out,
  // converter side
  input logic sleep_in,
  input logic wake_out,
  input logic [7:0] trial_code_out,
  input logic [2:0] channel_out,
  input logic acquire_out,
  input logic module_powered_out,
  input logic [5:0] port_direction_out
);
  logic wr_q;
  logic [7:0] wa_q;
  logic [7:0] ctl_q;
  logic [5:0] dir_q;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // shadow of the last control and direction writes, taken in the data phase
  always_ff @(posedge clk_sys_in)
  begin
    if (rst_in)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      ctl_q <= 8'h00;
      dir_q <= 6'h3F;
    end
    else
    begin
      wr_q <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
      wa_q <= haddr_in;
      if (wr_q && wa_q == 8'h00)
        ctl_q <= hwdata_in[7:0];
      if (wr_q && wa_q == 8'h0C)
        dir_q <= hwdata_in[5:0];
    end
  end
  chk_ready_okay: assert property (hreadyout_out && !hresp_out)
    else $error("slave not ready or not okay");
  chk_reset_values: assert property (disable iff (1'b0) rst_in |=> port_direction_out == 6'h3F
    && !module_powered_out && !acquire_out && trial_code_out == 8'h80 && !wake_out)
    else $error("reset values wrong");
  chk_rdata_holds: assert property (!(hsel_in && hready_in && htrans_in[1] && !hwrite_in)
    |=> $stable(hrdata_out)) else $error("read data moved without a read");
  chk_channel_follows: assert property (wr_q && wa_q == 8'h00 |=> ##[0:1]
    channel_out == ctl_q[5:3]) else $error("channel not taken from control");
  chk_direction_follows: assert property (wr_q && wa_q == 8'h0C |=> ##[0:1]
    port_direction_out == dir_q) else $error("direction not taken from write");
  chk_power_follows: assert property (wr_q && wa_q == 8'h00 && !sleep_in |=> ##[0:1]
    module_powered_out == ctl_q[0]) else $error("power state not from on bit");
  chk_sleep_abort: assert property ($rose(sleep_in) && module_powered_out
    && ctl_q[7:6] != 2'h3 |-> ##[0:2] !module_powered_out)
    else $error("sleep did not power down");
  chk_wake_sleep: assert property (wake_out |-> sleep_in)
    else $error("wake outside sleep");
  chk_acquire_powered: assert property (acquire_out |-> module_powered_out)
    else $error("acquiring while off");
endmodule
bind adc_conversion_sequencer adc_seq_props props (.*);

// ---- verif/afe_model.sv ----
`timescale 1ns/1ns
module afe_model #(parameter int RC_DIV = 5)
(
  input logic clk_sys_in,
  input logic rst_in,
  input logic [7:0] level_in,
  input logic [7:0] trial_code_in,
  input logic powered_in,
  output logic comparator_out,
  output logic rc_half_tick_out
);
  int cnt;
  // the rc oscillator runs free, unrelated to the converter state
  always @(posedge clk_sys_in)
    cnt <= (rst_in || cnt == RC_DIV - 1) ? 0 : cnt + 1;
  assign rc_half_tick_out = (cnt == RC_DIV - 1);
  // an unpowered front end gives no meaningful decision, so it toggles
  assign comparator_out = powered_in ? (level_in >= trial_code_in) : cnt[0];
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic [1:0] sel; logic [2:0] ch; logic [7:0] half; logic [7:0] ana;} row_t;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic hwrite = 1'b0, sleep = 1'b0;
  logic [7:0] haddr = 8'h00, level = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, rd_q, d;
  wire hready, hresp, cmp, tick, wake, acq, pwr;
  wire [31:0] hrdata;
  wire [7:0] trial;
  wire [2:0] chan;
  wire [5:0] dir;
  int failures = 0, checks = 0, cyc = 0, n, e;
  row_t rows [4];
  always #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) rd_q <= hrdata;
  adc_conversion_sequencer DUT (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .hsel_in(1'b1),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp),
    .hrdata_out(hrdata), .rc_half_tick_in(tick), .sleep_in(sleep), .wake_out(wake),
    .comparator_in(cmp), .trial_code_out(trial), .channel_out(chan), .acquire_out(acq),
    .module_powered_out(pwr), .port_pins_in(6'h3F), .port_direction_out(dir));
  afe_model #(.RC_DIV(5)) partner (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .level_in(level),
    .trial_code_in(trial), .powered_in(pwr), .comparator_out(cmp), .rc_half_tick_out(tick));
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one single transfer; read data is the value sampled at the data phase edge
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= v;
    do @(posedge clk_sys_in); while (hready !== 1'b1);
    #1 d = rd_q;
  endtask
  // cycles until acquisition resumes, sampled away from the active edge
  task automatic measure(output int k);
    k = 0;
    @(negedge clk_sys_in);
    while (acq === 1'b1 && k < 4)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    while (acq !== 1'b1 && k < 3000)
    begin
      @(negedge clk_sys_in);
      k++;
    end
    @(posedge clk_sys_in);
  endtask
  always @(posedge clk_sys_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      report_and_stop;
    end
  end
  initial
  begin
    rows[0] = '{2'h0, 3'h0, 8'h01, 8'h5A};
    rows[1] = '{2'h1, 3'h1, 8'h04, 8'hA5};
    rows[2] = '{2'h2, 3'h4, 8'h10, 8'hFF};
    rows[3] = '{2'h3, 3'h2, 8'h05, 8'h00};
    repeat (6) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    bus(8'h0C, 1'b0, 32'h0);
    chk("dir_reset", d, 32'h3F);
    bus(8'h00, 1'b0, 32'h0);
    chk("ctl_reset", d, 32'h00);
    bus(8'h40, 1'b1, 32'hFF);
    bus(8'h40, 1'b0, 32'h0);
    chk("unmapped", d, 32'h00);
    bus(8'h08, 1'b1, 32'h4);
    bus(8'h10, 1'b0, 32'h0);
    chk("port_cfg4", d, 32'h34);
    bus(8'h08, 1'b1, 32'h0);
    bus(8'h10, 1'b0, 32'h0);
    chk("port_cfg0", d, 32'h10);
    bus(8'h08, 1'b1, 32'h7);
    bus(8'h10, 1'b0, 32'h0);
    chk("port_cfg7", d, 32'h3F);
    bus(8'h00, 1'b1, 32'h04);
    bus(8'h00, 1'b0, 32'h0);
    chk("go_while_off", d, 32'h00);
    foreach (rows[i])
    begin
      level <= rows[i].ana;
      bus(8'h00, 1'b1, {24'h0, rows[i].sel, rows[i].ch, 3'h1});
      bus(8'h00, 1'b1, {24'h0, rows[i].sel, rows[i].ch, 3'h5});
      measure(n);
      e = 23 * rows[i].half + (rows[i].sel == 2'h3 ? 4 : 0);
      chk("conv_len", 32'(n >= e - rows[i].half - 3 && n <= e + rows[i].half + 3), 1);
      bus(8'h00, 1'b0, 32'h0);
      chk("ctl_done", d, {24'h0, rows[i].sel, rows[i].ch, 3'h1});
      bus(8'h04, 1'b0, 32'h0);
      chk("result", d, {24'h0, rows[i].ana});
      bus(8'h14, 1'b0, 32'h0);
      chk("flag_set", d, 32'h1);
      bus(8'h14, 1'b1, 32'h1);
      bus(8'h14, 1'b0, 32'h0);
      chk("flag_clear", d, 32'h0);
    end
    level <= 8'h77;
    bus(8'h04, 1'b1, 32'h3C);
    bus(8'h00, 1'b1, 32'h85);
    repeat (40) @(posedge clk_sys_in);
    bus(8'h00, 1'b1, 32'h81);
    measure(n);
    chk("abort_wait", 32'(n >= 55 && n <= 72), 1);
    bus(8'h00, 1'b0, 32'h0);
    chk("abort_ctl", d, 32'h81);
    bus(8'h04, 1'b0, 32'h0);
    chk("abort_keep", d, 32'h3C);
    // switch from div32 to div2 mid-conversion: later bits run fast
    bus(8'h00, 1'b1, 32'h85);
    repeat (100) @(posedge clk_sys_in);
    bus(8'h00, 1'b1, 32'h05);
    measure(n);
    chk("fast_switch", 32'(n >= 10 && n <= 30), 1);
    bus(8'h14, 1'b1, 32'h1);
    bus(8'h00, 1'b1, 32'h45);
    repeat (10) @(posedge clk_sys_in);
    sleep <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("sleep_off", {31'h0, pwr}, 32'h0);
    @(posedge clk_sys_in);
    bus(8'h00, 1'b0, 32'h0);
    chk("sleep_on_bit", d, 32'h41);
    sleep <= 1'b0;
    bus(8'h14, 1'b1, 32'h2);
    bus(8'h00, 1'b1, 32'hC1);
    bus(8'h00, 1'b1, 32'hC5);
    sleep <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk("wake", {31'h0, wake}, 32'h1);
    @(posedge clk_sys_in);
    sleep <= 1'b0;
    bus(8'h14, 1'b1, 32'h1);
    bus(8'h00, 1'b1, 32'hC5);
    sleep <= 1'b1;
    repeat (200) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    chk("rc_sleep_off", {30'h0, pwr, wake}, 32'h0);
    @(posedge clk_sys_in);
    bus(8'h00, 1'b0, 32'h0);
    chk("rc_on_bit", d, 32'hC1);
    sleep <= 1'b0;
    report_and_stop;
  end
endmodule
